// file: hw/i2bl_link.sv
// Two-wire serial slave bit link with power-on gating and a system-clock user side.
`timescale 1ns/10ps
`include "i2bl_defines.svh"

module i2bl_link
    import i2bl_pkg::*;
#(
    parameter int PUP_WAIT_CYC = `I2BL_PUP_WAIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       lnk_clk,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       supply_ok,
    input  wire logic       ack_en,
    input  wire logic       send_mode,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_write,
    output logic            tx_busy,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            master_nack,
    output logic            bus_idle
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: pin sampling and control level crossing.

    logic [`I2BL_LNK_SYNC_W-1:0] lnk_sync;
    logic                        tx_req_q;
    logic [7:0]                  tx_buf_q;

    i2bl_sync #(.W(`I2BL_LNK_SYNC_W)) u_lnk_sync (
        .clk  (lnk_clk),
        .rst  (rst),
        .din  ({tx_req_q, send_mode, ack_en, supply_ok, sda_i, scl_i}),
        .dout (lnk_sync)
    );

    logic scl_s, sda_s, por_ok_s, ack_en_s, send_s, tx_req_s;
    assign scl_s    = lnk_sync[0];
    assign sda_s    = lnk_sync[1];
    assign por_ok_s = lnk_sync[2];
    assign ack_en_s = lnk_sync[3];
    assign send_s   = lnk_sync[4];
    assign tx_req_s = lnk_sync[5];

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: bit framing state machine.

    i2bl_state_e st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  rx_byte_q, rx_byte_d;
    logic [7:0]  tx_lnk_q, tx_lnk_d;
    logic        oe_q, oe_d;
    logic        scl_p_q, sda_p_q, req_p_q;
    logic        mnack_q, mnack_d;
    logic        idle_q, idle_d;
    logic        rx_tgl_q, rx_tgl_d;
    logic        sta_tgl_q, sta_tgl_d;
    logic        sto_tgl_q, sto_tgl_d;
    logic        nak_tgl_q, nak_tgl_d;
    logic        tx_ack_q, tx_ack_d;
    logic        scl_rise, scl_fall, start_c, stop_c;

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        rx_byte_d = rx_byte_q;
        tx_lnk_d  = tx_lnk_q;
        oe_d      = oe_q;
        mnack_d   = mnack_q;
        rx_tgl_d  = rx_tgl_q;
        sta_tgl_d = sta_tgl_q;
        sto_tgl_d = sto_tgl_q;
        nak_tgl_d = nak_tgl_q;
        tx_ack_d  = tx_ack_q;
        idle_d    = scl_s & sda_s;
        // A new transmit byte is taken only once its word has settled on the far side.
        if (tx_req_s != req_p_q) begin
            tx_lnk_d = tx_buf_q;
            tx_ack_d = tx_req_s;
        end
        if (!por_ok_s) begin
            st_d = I2BL_STANDBY;
            oe_d = 1'b0;
        end else if (start_c) begin
            st_d      = I2BL_RECV;
            cnt_d     = `I2BL_CNT_ZERO;
            oe_d      = 1'b0;
            sta_tgl_d = ~sta_tgl_q;
        end else if (stop_c) begin
            st_d      = I2BL_STANDBY;
            oe_d      = 1'b0;
            sto_tgl_d = ~sto_tgl_q;
        end else begin
            case (st_q)
                I2BL_RECV: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + `I2BL_CNT_ONE;
                    end else if (scl_fall && cnt_q == `I2BL_BYTE_BITS) begin
                        st_d      = I2BL_ACK;
                        oe_d      = ack_en_s;
                        rx_byte_d = sh_q;
                        rx_tgl_d  = ~rx_tgl_q;
                    end
                end
                I2BL_ACK: begin
                    if (scl_fall) begin
                        cnt_d = `I2BL_CNT_ZERO;
                        if (!oe_q) begin
                            oe_d = 1'b0;
                            st_d = I2BL_HOLD;
                        end else if (send_s) begin
                            // first data bit out at fall
                            sh_d = tx_lnk_d;
                            oe_d = ~tx_lnk_d[7];
                            st_d = I2BL_SEND;
                        end else begin
                            oe_d = 1'b0;
                            st_d = I2BL_RECV;
                        end
                    end
                end
                I2BL_SEND: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + `I2BL_CNT_ONE;
                    end else if (scl_fall) begin
                        if (cnt_q == `I2BL_BYTE_BITS) begin
                            oe_d = 1'b0;
                            st_d = I2BL_MACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                I2BL_MACK: begin
                    if (scl_rise) begin
                        mnack_d = sda_s;
                    end else if (scl_fall) begin
                        cnt_d = `I2BL_CNT_ZERO;
                        if (mnack_q) begin
                            oe_d      = 1'b0;
                            st_d      = I2BL_HOLD;
                            nak_tgl_d = ~nak_tgl_q;
                        end else begin
                            sh_d = tx_lnk_d;
                            oe_d = ~tx_lnk_d[7];
                            st_d = I2BL_SEND;
                        end
                    end
                end
                I2BL_STANDBY,
                I2BL_HOLD: begin
                    oe_d = 1'b0;
                end
                default: begin
                    st_d = I2BL_STANDBY;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            st_q      <= I2BL_STANDBY;
            cnt_q     <= `I2BL_CNT_ZERO;
            sh_q      <= `I2BL_BYTE_ZERO;
            rx_byte_q <= `I2BL_BYTE_ZERO;
            tx_lnk_q  <= `I2BL_BYTE_ZERO;
            oe_q      <= 1'b0;
            scl_p_q   <= 1'b0;
            sda_p_q   <= 1'b0;
            req_p_q   <= 1'b0;
            mnack_q   <= 1'b0;
            idle_q    <= 1'b0;
            rx_tgl_q  <= 1'b0;
            sta_tgl_q <= 1'b0;
            sto_tgl_q <= 1'b0;
            nak_tgl_q <= 1'b0;
            tx_ack_q  <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            sh_q      <= sh_d;
            rx_byte_q <= rx_byte_d;
            tx_lnk_q  <= tx_lnk_d;
            oe_q      <= oe_d;
            scl_p_q   <= scl_s;
            sda_p_q   <= sda_s;
            req_p_q   <= tx_req_s;
            mnack_q   <= mnack_d;
            idle_q    <= idle_d;
            rx_tgl_q  <= rx_tgl_d;
            sta_tgl_q <= sta_tgl_d;
            sto_tgl_q <= sto_tgl_d;
            nak_tgl_q <= nak_tgl_d;
            tx_ack_q  <= tx_ack_d;
        end
    end

    // The pin output is always low; only the enable moves, so the line is open drain.
    assign sda_oe = oe_q;
    always_ff @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: event toggles back from the link, transmit word handshake.

    logic [`I2BL_SYS_SYNC_W-1:0] sys_sync;
    logic [4:0]                  tgl_p_q;
    logic [4:0]                  tgl_edge;
    logic [7:0]                  rx_data_d, tx_buf_d;
    logic                        tx_req_d, tx_busy_d;

    i2bl_sync #(.W(`I2BL_SYS_SYNC_W)) u_sys_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({idle_q, tx_ack_q, nak_tgl_q, sto_tgl_q, sta_tgl_q, rx_tgl_q}),
        .dout (sys_sync)
    );

    assign tgl_edge = sys_sync[4:0] ^ tgl_p_q;

    always_comb begin
        rx_data_d = rx_data;
        tx_buf_d  = tx_buf_q;
        tx_req_d  = tx_req_q;
        // The received byte is read only after its toggle has crossed, so it is stable.
        if (tgl_edge[0]) begin
            rx_data_d = rx_byte_q;
        end
        // Writes while busy are dropped so the word seen by the link never changes in flight.
        if (tx_write && !tx_busy) begin
            tx_buf_d = tx_data;
            tx_req_d = ~tx_req_q;
        end
        tx_busy_d = (tx_req_d != sys_sync[4]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tgl_p_q     <= 5'h0_0;
            rx_data     <= `I2BL_BYTE_ZERO;
            rx_valid    <= 1'b0;
            start_seen  <= 1'b0;
            stop_seen   <= 1'b0;
            master_nack <= 1'b0;
            bus_idle    <= 1'b0;
            tx_buf_q    <= `I2BL_BYTE_ZERO;
            tx_req_q    <= 1'b0;
            tx_busy     <= 1'b0;
        end else begin
            tgl_p_q     <= sys_sync[4:0];
            rx_data     <= rx_data_d;
            rx_valid    <= tgl_edge[0];
            start_seen  <= tgl_edge[1];
            stop_seen   <= tgl_edge[2];
            master_nack <= tgl_edge[3];
            bus_idle    <= sys_sync[5];
            tx_buf_q    <= tx_buf_d;
            tx_req_q    <= tx_req_d;
            tx_busy     <= tx_busy_d;
        end
    end

endmodule

// file: inc/i2bl_defines.svh
// Shared constants of the two-wire slave bit link.
`ifndef I2BL_DEFINES_SVH
`define I2BL_DEFINES_SVH

`define I2BL_BYTE_BITS      4'h8
`define I2BL_CNT_ZERO       4'h0
`define I2BL_CNT_ONE        4'h1
`define I2BL_BYTE_ZERO      8'h00
`define I2BL_PUP_WAIT_US    100
`define I2BL_CLK_MHZ        10
`define I2BL_PUP_WAIT_CYC   (`I2BL_PUP_WAIT_US * `I2BL_CLK_MHZ)
`define I2BL_LNK_PINS       3
`define I2BL_LNK_SYNC_W     6
`define I2BL_SYS_SYNC_W     6

`endif

// file: inc/i2bl_pkg.sv
// Types of the two-wire slave bit link.
package i2bl_pkg;

    typedef enum logic [2:0] {
        I2BL_STANDBY,
        I2BL_RECV,
        I2BL_ACK,
        I2BL_SEND,
        I2BL_MACK,
        I2BL_HOLD
    } i2bl_state_e;

endpackage

// file: hw/i2bl_sync.sv
// Two flip-flop synchroniser for a group of independent levels.
`timescale 1ns/10ps

module i2bl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q[g] <= 1'b0;
                    dout[g]   <= 1'b0;
                end else begin
                    meta_q[g] <= din[g];
                    dout[g]   <= meta_q[g];
                end
            end
        end
    endgenerate

endmodule

// file: testbench/i2bl_link_properties.sv
// Port checks of the two-wire slave bit link.
`timescale 1ns/10ps
module i2bl_link_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       lnk_clk,
    input wire logic       scl_i,
    input wire logic       supply_ok,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       tx_busy,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       start_seen,
    input wire logic       master_nack,
    input wire logic       bus_idle
);
    a_power_gate: assert property (@(posedge lnk_clk) disable iff (rst)
        (!supply_ok) [*4] |-> !sda_oe) else $error("data driven without supply");
    // The answer lands 3 link edges after a clock fall, so a long high phase must be quiet.
    a_oe_steady: assert property (@(posedge lnk_clk) disable iff (rst)
        (scl_i && supply_ok) [*5] |-> $stable(sda_oe)) else $error("data moved in high");
    a_drive_low: assert property (@(posedge lnk_clk) disable iff (rst)
        sda_oe |-> !sda_o) else $error("driven level not low");
    a_rx_with_valid: assert property (@(posedge clk) disable iff (rst)
        $changed(rx_data) |-> rx_valid) else $error("rx byte moved alone");
    a_rx_pulse: assert property (@(posedge clk) disable iff (rst)
        rx_valid |=> !rx_valid) else $error("rx pulse too long");
    a_start_pulse: assert property (@(posedge clk) disable iff (rst)
        start_seen |=> !start_seen) else $error("start pulse too long");
    a_nack_pulse: assert property (@(posedge clk) disable iff (rst)
        $rose(master_nack) |=> $fell(master_nack)) else $error("nack pulse too long");
    a_busy_clears: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_busy) |-> ##[1:40] !tx_busy) else $error("tx byte never taken");
    a_idle_low: assert property (@(posedge clk) disable iff (rst)
        (!scl_i) [*8] |-> ##2 !bus_idle) else $error("idle with clock low");
    c_rx: cover property (@(posedge clk) rx_valid);
    c_nack: cover property (@(posedge clk) master_nack);
    c_drive: cover property (@(posedge lnk_clk) $rose(sda_oe));
endmodule
////////////////////////////////
bind i2bl_link i2bl_link_properties u_props (
    .clk(clk), .rst(rst), .lnk_clk(lnk_clk), .scl_i(scl_i), .supply_ok(supply_ok),
    .sda_o(sda_o), .sda_oe(sda_oe), .tx_busy(tx_busy), .rx_data(rx_data),
    .rx_valid(rx_valid), .start_seen(start_seen), .master_nack(master_nack),
    .bus_idle(bus_idle)
);

// file: testbench/i2bl_master_model.sv
// Behavioural bus master that clocks frames onto the two-wire link.
`timescale 1ns/10ps
module i2bl_master_model (
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    int half_ns = 1000;
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    ////////////////////////////////
    // master opens and closes frames and clocks bits and bytes
    task automatic start();
        sda_pull = 1'b0;
        #(half_ns) scl = 1'b1;
        #(half_ns) sda_pull = 1'b1;
        #(half_ns) scl = 1'b0;
    endtask
    task automatic stop();
        #(half_ns/2) sda_pull = 1'b1;
        #(half_ns/2) scl = 1'b1;
        #(half_ns) sda_pull = 1'b0;
        #(half_ns);
    endtask
    task automatic bit_io(input logic b, output logic r);
        #(half_ns/2) sda_pull = !b;
        #(half_ns/2) scl = 1'b1;
        #(half_ns/2) r = sda;
        #(half_ns/2) scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// file: testbench/tb_i2c_eeprom_bit_link.sv
// Self-checking bench of the two-wire slave bit link.
`timescale 1ns/10ps
module tb_i2c_eeprom_bit_link;
    logic       clk = 1'b0;
    logic       lnk_clk = 1'b0;
    logic       rst = 1'b0;
    logic       supply_ok = 1'b0;
    logic       ack_en = 1'b0;
    logic       send_mode = 1'b0;
    logic       tx_write = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       rx_ign = 1'b0;
    logic       scl, sda_pull, sda_o, sda_oe, tx_busy, rx_valid;
    logic       start_seen, stop_seen, master_nack, bus_idle;
    logic [7:0] rx_data;
    logic [7:0] exp_q[$];
    int         fail_count = 0;
    int         comparisons = 0;
    int         seed = 43;
    int         cnt[3] = '{0, 0, 0};
    int         ecnt[3] = '{0, 0, 0};
    wire        sda = !(sda_pull || (sda_oe && !sda_o));
    always #50 clk = ~clk;
    initial begin
        #17;
        forever #62.5 lnk_clk = ~lnk_clk;
    end
    i2bl_link #(.PUP_WAIT_CYC(1000)) DUT (
        .clk(clk), .rst(rst), .lnk_clk(lnk_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .supply_ok(supply_ok), .ack_en(ack_en), .send_mode(send_mode),
        .tx_data(tx_data), .tx_write(tx_write), .tx_busy(tx_busy), .rx_data(rx_data),
        .rx_valid(rx_valid), .start_seen(start_seen), .stop_seen(stop_seen),
        .master_nack(master_nack), .bus_idle(bus_idle));
    i2bl_master_model mst (.sda(sda), .scl(scl), .sda_pull(sda_pull));
    ////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic load(input logic [7:0] d);
        int n;
        @(negedge clk);
        tx_data = d;
        tx_write = 1'b1;
        @(negedge clk);
        tx_write = 1'b0;
        for (n = 0; n < 100 && tx_busy !== 1'b0; n++) @(negedge clk);
        if (n == 100) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic ends(input string nm);
        repeat (20) @(negedge clk);
        for (int i = 0; i < 3; i++) chk("event count", 8'(ecnt[i]), 8'(cnt[i]));
        chk("left over", 8'h00, 8'(exp_q.size()));
        $display("test %s done", nm);
    endtask
    // A byte nobody expects pops an unknown, so a stray receive mismatches whenever rx_ign is clear.
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && !rx_ign)
            chk("rx_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_data);
        cnt[0] += int'(start_seen === 1'b1);
        cnt[1] += int'(stop_seen === 1'b1);
        cnt[2] += int'(master_nack === 1'b1);
    end
    initial begin
        #2_000_000;
        fail_count++;
        give_verdict();
    end
    initial begin
        logic [7:0] b, c, got;
        logic       a;
        #1 rst = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk("sda_oe", 8'h00, {7'h0, sda_oe});
        mst.start();
        mst.put_byte(8'($random(seed)), a);
        chk("ack", 8'h01, {7'h0, a});
        mst.stop();
        ends("power off");
        @(negedge clk);
        supply_ok = 1'b1;
        ack_en = 1'b1;
        #100_000;
        chk("bus_idle", 8'h01, {7'h0, bus_idle});
        mst.start();
        for (int i = 0; i < 5; i++) begin
            b = i < 2 ? {8{i[0]}} : 8'($random(seed));
            exp_q.push_back(b);
            mst.put_byte(b, a);
            chk("ack", 8'h00, {7'h0, a});
        end
        chk("bus_idle", 8'h00, {7'h0, bus_idle});
        mst.stop();
        ecnt = '{1, 1, 0};
        ends("write burst");
        @(negedge clk) ack_en = 1'b0;
        rx_ign = 1'b1;
        mst.start();
        mst.put_byte(8'($random(seed)), a);
        chk("nack", 8'h01, {7'h0, a});
        @(negedge clk) ack_en = 1'b1;
        mst.start();
        repeat (3) mst.bit_io(1'b0, a);
        rx_ign = 1'b0;
        mst.start();
        b = 8'($random(seed));
        exp_q.push_back(b);
        mst.put_byte(b, a);
        chk("ack", 8'h00, {7'h0, a});
        mst.stop();
        ecnt = '{4, 2, 0};
        ends("restart");
        // A slow master stretches every phase well past the sampling latency.
        @(negedge clk) send_mode = 1'b1;
        mst.half_ns = 2500;
        b = 8'($random(seed));
        c = 8'($random(seed));
        load(b);
        mst.start();
        got = 8'($random(seed));
        exp_q.push_back(got);
        mst.put_byte(got, a);
        chk("ack", 8'h00, {7'h0, a});
        fork
            mst.get_byte(1'b0, got);
            begin
                #3000;
                load(c);
            end
        join
        chk("read byte", b, got);
        mst.get_byte(1'b1, got);
        chk("read byte", c, got);
        #1000;
        chk("sda_oe", 8'h00, {7'h0, sda_oe});
        mst.stop();
        ecnt = '{5, 3, 1};
        ends("read");
        give_verdict();
    end
endmodule
